/* File: rtc_params.svh */
// offsets, field positions, reset values and timing counts of the clock block
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// two-wire device address, upper seven bits of the address byte
`define RTC_DEV_ADDR 7'h51
// register offsets
`define RTC_REG_CTRL 8'h00
`define RTC_REG_OFFS 8'h02
`define RTC_REG_SEC 8'h04
`define RTC_REG_LAST 8'h0A
// field positions
`define RTC_CTRL_CAP_BIT 0
`define RTC_CTRL_12H_BIT 1
`define RTC_SEC_OSF_BIT 7
`define RTC_HOUR_PM_BIT 5
`define RTC_OFFS_MODE_BIT 7
// reset values
`define RTC_CTRL_RST 8'h00
`define RTC_OFFS_RST 8'h00
`define RTC_TIME_RST 8'h00
`define RTC_DAY_RST 8'h01
`define RTC_MON_RST 8'h01
`define RTC_OSF_RST 1'b1
// timing
`define RTC_XTAL_HZ 32768
`define RTC_CORR_M0_HOURS 2
`define RTC_CORR_M1_MINUTES 4
`define RTC_CORR_M0_SEC (`RTC_CORR_M0_HOURS * 3600)
`define RTC_CORR_M1_SEC (`RTC_CORR_M1_MINUTES * 60)
`define RTC_CLK_PERIOD_NS 40
`define RTC_XTAL_PERIOD_NS 30518
`define RTC_XTAL_LOSS_NS (4 * `RTC_XTAL_PERIOD_NS)
`define RTC_XTAL_LOSS_CYC (`RTC_XTAL_LOSS_NS / `RTC_CLK_PERIOD_NS)
`endif

/* File: rtc_pkg.sv */
// types shared by the clock block modules
package rtc_pkg;
   // two-wire slave states, one-hot
   typedef enum logic [6:0] {
      RTC_IDLE  = 7'h01,
      RTC_ADDR  = 7'h02,
      RTC_ACK_A = 7'h04,
      RTC_WRITE = 7'h08,
      RTC_ACK_W = 7'h10,
      RTC_READ  = 7'h20,
      RTC_RACK  = 7'h40
   } rtc_i2c_st_t;
endpackage : rtc_pkg

/* File: rtc_bus_if.sv */
// byte-level carrier between the two-wire slave and the register core
`timescale 1ns/10ps
interface rtc_bus_if;
   logic wr_stb; // one-cycle pulse, byte received
   logic wr_first; // received byte is the pointer byte
   logic [7:0] wr_data; // received byte
   logic rd_stb; // one-cycle pulse, rd_data taken for sending
   logic [7:0] rd_data; // register at pointer
   logic busy; // access in progress
   modport slave (output wr_stb, output wr_first, output wr_data, output rd_stb,
      output busy, input rd_data);
   modport regs (input wr_stb, input wr_first, input wr_data, input rd_stb,
      input busy, output rd_data);
endinterface : rtc_bus_if

/* File: rtc_i2c_slave.sv */
// two-wire slave byte engine of the clock block
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_i2c_slave (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   rtc_bus_if.slave bus
);
   import rtc_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   logic scl_m, scl_s, scl_d; // scl synchroniser and delay
   logic sda_m, sda_s, sda_d; // sda synchroniser and delay
   rtc_i2c_st_t st; // slave state
   logic [3:0] cnt; // bit count within a byte
   logic [7:0] sh; // receive shifter
   logic [7:0] tx; // transmit shifter
   logic rw; // read requested
   logic first; // next byte is the pointer
   logic mack; // master acked last byte
   // edges, only ever from the second stage onward
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
   wire addr_hit = (sh[7:1] == `RTC_DEV_ADDR);
   wire [7:0] sh_next = {sh[6:0], sda_s};
   // busy covers the access until stop or the master's final nack, so time stays frozen until then
   assign bus.busy = (st != RTC_IDLE);
   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // byte engine; ack and data change only after scl falls
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= RTC_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         first <= 1'b0;
         mack <= 1'b0;
         sda_oe_o <= 1'b0;
         bus.wr_stb <= 1'b0;
         bus.wr_first <= 1'b0;
         bus.wr_data <= 8'h00;
         bus.rd_stb <= 1'b0;
      end else begin
         bus.wr_stb <= 1'b0;
         bus.rd_stb <= 1'b0;
         if (start_c) begin // start or repeated start
            st <= RTC_ADDR;
            cnt <= 4'h0;
            first <= 1'b1;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            st <= RTC_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (st)
               RTC_ADDR, RTC_WRITE: begin
                  if (scl_rise) begin
                     sh <= sh_next;
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall && cnt == 4'h8) begin
                     if (st == RTC_WRITE) begin
                        bus.wr_stb <= 1'b1;
                        bus.wr_data <= sh;
                        bus.wr_first <= first;
                        sda_oe_o <= 1'b1;
                        st <= RTC_ACK_W;
                     end else if (addr_hit) begin
                        rw <= sh[0];
                        sda_oe_o <= 1'b1;
                        st <= RTC_ACK_A;
                     end else begin
                        st <= RTC_IDLE; // not our address
                     end
                  end
               end
               RTC_ACK_A, RTC_RACK: begin
                  if (scl_rise) begin
                     mack <= ~sda_s;
                  end else if (scl_fall) begin
                     if ((st == RTC_ACK_A && rw) || (st == RTC_RACK && mack)) begin
                        tx <= bus.rd_data;
                        sda_oe_o <= ~bus.rd_data[7];
                        bus.rd_stb <= 1'b1;
                        cnt <= 4'h1;
                        st <= RTC_READ;
                     end else if (st == RTC_ACK_A) begin
                        sda_oe_o <= 1'b0;
                        cnt <= 4'h0;
                        st <= RTC_WRITE;
                     end else begin
                        st <= RTC_IDLE; // master nack ends the burst
                     end
                  end
               end
               RTC_ACK_W: begin
                  if (scl_fall) begin
                     sda_oe_o <= 1'b0;
                     first <= 1'b0;
                     cnt <= 4'h0;
                     st <= RTC_WRITE;
                  end
               end
               RTC_READ: begin
                  if (scl_fall) begin
                     if (cnt == 4'h8) begin
                        sda_oe_o <= 1'b0;
                        st <= RTC_RACK;
                     end else begin
                        tx <= {tx[6:0], 1'b0};
                        sda_oe_o <= ~tx[6];
                        cnt <= cnt + 4'h1;
                     end
                  end
               end
               default: st <= RTC_IDLE;
            endcase
         end
      end
   end
endmodule : rtc_i2c_slave

/* File: rtc_core_top.sv */
// real-time clock core: register file, calendar, rate correction
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_core_top #(
   parameter int unsigned XTAL_HZ = `RTC_XTAL_HZ,
   parameter int unsigned CORR_M0_SEC = `RTC_CORR_M0_SEC,
   parameter int unsigned CORR_M1_SEC = `RTC_CORR_M1_SEC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic xtal_i,
   output logic clock_output_pin_o,
   output logic cap_12p5_o
);
   import rtc_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [11:0] LOSS_CYC = 12'(`RTC_XTAL_LOSS_CYC);
   rtc_bus_if bus (); // byte carrier to the slave
   logic [7:0] ctrl; // control word
   logic [7:0] offs; // offset correction
   logic [7:0] tm [0:6]; // sec..year, bcd
   logic osc_stop_flag; // oscillator integrity
   logic [7:0] ptr; // register pointer
   logic xt_m, xt_s, xt_d; // crystal synchroniser
   logic [16:0] xt_cnt; // crystal edges in current second
   logic [12:0] corr_cnt; // seconds since last correction
   logic [11:0] loss_cnt; // clocks since last crystal edge
   logic pend; // seconds increment waiting for bus idle
   ////////////////////////////////////////////////////////////////////////
   // bcd increment of a two-digit value
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_inc
   // pointer addresses one of the time registers
   function automatic logic is_time(input logic [7:0] p);
      is_time = (p >= `RTC_REG_SEC) && (p <= `RTC_REG_LAST);
   endfunction : is_time
   ////////////////////////////////////////////////////////////////////////
   // calendar decode
   wire [2:0] tix = 3'(ptr - `RTC_REG_SEC); // time register index
   wire h12 = ctrl[`RTC_CTRL_12H_BIT];
   wire pm = tm[2][`RTC_HOUR_PM_BIT];
   wire [4:0] hv = tm[2][4:0];
   wire [7:0] hv_inc = bcd_inc({3'h0, hv});
   wire [3:0] yt = tm[6][7:4];
   wire [3:0] yu = tm[6][3:0];
   // year divisible by four, worked on bcd digits
   wire leap = (~yt[0] & (yu == 4'h0 || yu == 4'h4 || yu == 4'h8)) |
      (yt[0] & (yu == 4'h2 || yu == 4'h6));
   wire [7:0] mlen = (tm[5] == 8'h02) ? (leap ? 8'h29 : 8'h28) :
      (tm[5] == 8'h04 || tm[5] == 8'h06 || tm[5] == 8'h09 || tm[5] == 8'h11) ?
      8'h30 : 8'h31;
   wire c_sec = (tm[0][6:0] == 7'h59);
   wire c_min = c_sec & (tm[1] == 8'h59);
   // 11 pm to 12 am rolls the day in 12-hour mode
   wire hr_end = h12 ? (hv == 5'h11 && pm) : (tm[2] == 8'h23);
   wire c_hr = c_min & hr_end;
   wire c_day = c_hr & (tm[3] == mlen);
   wire c_mon = c_day & (tm[5] == 8'h12);
   wire [7:0] nx_sec = c_sec ? 8'h00 : bcd_inc({1'b0, tm[0][6:0]});
   wire [7:0] nx_min = (tm[1] == 8'h59) ? 8'h00 : bcd_inc(tm[1]);
   wire [7:0] nx_h12 = (hv == 5'h12) ? {2'h0, pm, 5'h01} :
      (hv == 5'h11) ? {2'h0, ~pm, 5'h12} : {2'h0, pm, hv_inc[4:0]};
   wire [7:0] nx_h24 = (tm[2] == 8'h23) ? 8'h00 : bcd_inc(tm[2]);
   wire [7:0] nx_day = (tm[3] == mlen) ? 8'h01 : bcd_inc(tm[3]);
   wire [7:0] nx_wd = (tm[4] == 8'h06) ? 8'h00 : 8'(tm[4] + 8'h01);
   wire [7:0] nx_mon = (tm[5] == 8'h12) ? 8'h01 : bcd_inc(tm[5]);
   wire [7:0] nx_yr = (tm[6] == 8'h99) ? 8'h00 : bcd_inc(tm[6]);
   ////////////////////////////////////////////////////////////////////////
   // register access decode
   wire wr_reg = bus.wr_stb & ~bus.wr_first;
   wire wr_ctrl = wr_reg & (ptr == `RTC_REG_CTRL);
   wire wr_offs = wr_reg & (ptr == `RTC_REG_OFFS);
   wire wr_time = wr_reg & is_time(ptr);
   wire wr_sec = wr_reg & (ptr == `RTC_REG_SEC);
   wire [7:0] ptr_inc = (ptr == `RTC_REG_LAST) ? 8'h00 : 8'(ptr + 8'h01);
   // read mux, unmapped offsets read as zero
   assign bus.rd_data = (ptr == `RTC_REG_CTRL) ? ctrl :
      (ptr == `RTC_REG_OFFS) ? offs :
      (ptr == `RTC_REG_SEC) ? {osc_stop_flag, tm[0][6:0]} :
      is_time(ptr) ? tm[tix] : 8'h00;
   // the pull-up makes the high level, so only low is ever driven
   assign sda_o = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // timebase decode
   wire xt_rise = xt_s & ~xt_d;
   wire mode1 = offs[`RTC_OFFS_MODE_BIT];
   wire [12:0] corr_per = mode1 ? 13'(CORR_M1_SEC) : 13'(CORR_M0_SEC);
   // at or past the period end, so a switch to the shorter period cannot strand the count
   wire corr_now = (corr_cnt >= corr_per - 13'h1);
   // positive offset shortens the corrected second, negative lengthens it
   wire [16:0] sec_len = corr_now ? 17'(XTAL_HZ) - {{10{offs[6]}}, offs[6:0]} :
      17'(XTAL_HZ);
   wire sec_tick = xt_rise & (xt_cnt == sec_len - 17'h1);
   wire xtal_lost = (loss_cnt == LOSS_CYC - 12'h1);
   wire apply = pend & ~bus.busy;
   ////////////////////////////////////////////////////////////////////////
   rtc_i2c_slave u_slave (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_o),
      .bus(bus)
   );
   ////////////////////////////////////////////////////////////////////////
   // crystal synchroniser and clock output
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {xt_m, xt_s, xt_d} <= 3'h0;
         clock_output_pin_o <= 1'b0;
         cap_12p5_o <= 1'b0;
      end else begin
         {xt_m, xt_s, xt_d} <= {xtal_i, xt_m, xt_s};
         clock_output_pin_o <= xt_s;
         cap_12p5_o <= ctrl[`RTC_CTRL_CAP_BIT];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // prescaler, correction period and crystal watchdog
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         xt_cnt <= 17'h0_0000;
         corr_cnt <= 13'h0000;
         loss_cnt <= 12'h000;
         pend <= 1'b0;
      end else begin
         // a setting of the seconds restarts the running second
         if (wr_sec || sec_tick) begin
            xt_cnt <= 17'h0_0000;
         end else if (xt_rise) begin
            xt_cnt <= xt_cnt + 17'h0_0001;
         end
         if (sec_tick) begin
            corr_cnt <= corr_now ? 13'h0000 : corr_cnt + 13'h0001;
         end
         if (xt_rise) begin
            loss_cnt <= 12'h000;
         end else if (!xtal_lost) begin
            loss_cnt <= loss_cnt + 12'h001;
         end
         // new tick wins over the one being applied
         // a host write of the seconds also drops a tick still waiting
         pend <= (sec_tick | (pend & bus.busy)) & ~wr_sec;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // pointer and control registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ptr <= 8'h00;
         ctrl <= `RTC_CTRL_RST;
         offs <= `RTC_OFFS_RST;
         osc_stop_flag <= `RTC_OSF_RST;
      end else begin
         if (bus.wr_stb && bus.wr_first) begin
            ptr <= bus.wr_data;
         end else if (wr_reg || bus.rd_stb) begin
            ptr <= ptr_inc;
         end
         if (wr_ctrl) begin
            ctrl <= bus.wr_data;
         end
         if (wr_offs) begin
            offs <= bus.wr_data;
         end
         // a stopped crystal wins over a host clear
         if (xtal_lost) begin
            osc_stop_flag <= 1'b1;
         end else if (wr_sec) begin
            osc_stop_flag <= bus.wr_data[`RTC_SEC_OSF_BIT];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // time registers: host writes while busy, increments only when idle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 7; i++) begin
            tm[i] <= `RTC_TIME_RST;
         end
         tm[3] <= `RTC_DAY_RST;
         tm[5] <= `RTC_MON_RST;
      end else if (wr_time) begin
         tm[tix] <= bus.wr_data;
      end else if (apply) begin
         tm[0] <= nx_sec;
         if (c_sec) begin
            tm[1] <= nx_min;
         end
         if (c_min) begin
            tm[2] <= h12 ? nx_h12 : nx_h24;
         end
         if (c_hr) begin
            tm[3] <= nx_day;
            tm[4] <= nx_wd;
         end
         if (c_day) begin
            tm[5] <= nx_mon;
         end
         if (c_mon) begin
            tm[6] <= nx_yr;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_ptr_set;
      bus.wr_stb && bus.wr_first;
   endsequence
   sequence s_data_to(logic [7:0] a);
      bus.wr_stb && !bus.wr_first && ptr == a;
   endsequence
   property p_ptr_load;
      s_ptr_set |=> ptr == $past(bus.wr_data);
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
   property p_ctrl_wr;
      s_data_to(`RTC_REG_CTRL) |=> ctrl == $past(bus.wr_data) ##2 cap_12p5_o == ctrl[0];
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
   property p_offs_wr;
      s_data_to(`RTC_REG_OFFS) |=> offs == $past(bus.wr_data) && ptr == 8'h03;
   endproperty
   a_offs_wr: assert property (p_offs_wr) else $error("offset write lost");
   property p_rd_adv;
      bus.rd_stb && ptr == `RTC_REG_SEC |=> ptr == 8'h05 && bus.rd_data == tm[1];
   endproperty
   a_rd_adv: assert property (p_rd_adv) else $error("read pointer stuck");
   property p_freeze;
      bus.busy && !bus.wr_stb |=> $stable(tm[0]) && $stable(tm[1]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("time moved during access");
   property p_pend_run;
      sec_tick && !bus.busy && !wr_time ##1 !bus.busy |=> tm[0] != $past(tm[0], 2);
   endproperty
   a_pend_run: assert property (p_pend_run) else $error("increment lost");
   property p_osf;
      xtal_lost |=> osc_stop_flag ##0 bus.rd_data[7] || ptr != `RTC_REG_SEC;
   endproperty
   a_osf: assert property (p_osf) else $error("stop flag not set");
   property p_clock_output_pin;
      xt_rise |=> clock_output_pin_o;
   endproperty
   a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out not following");
   property p_corr_len;
      sec_tick && corr_now |=> !corr_now;
   endproperty
   a_corr_len: assert property (p_corr_len) else $error("correction repeated");
   property p_mode_per;
      sec_tick && corr_cnt == 13'(CORR_M1_SEC) - 13'h1 && mode1 |=> corr_cnt == 13'h0000;
   endproperty
   a_mode_per: assert property (p_mode_per) else $error("mode 1 period wrong");
   property p_day_roll;
      apply && !wr_time && c_day |=> tm[3] == 8'h01;
   endproperty
   a_day_roll: assert property (p_day_roll) else $error("month end missed");
   property p_h12;
      apply && !wr_time && h12 && c_min && hv == 5'h11 |=> tm[2][5] != $past(tm[2][5]);
   endproperty
   a_h12: assert property (p_h12) else $error("pm not toggled");
endmodule : rtc_core_top

/* File: rtc_i2c_master.sv */
// two-wire host model that talks to the clock block from the far side
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_i2c_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   int nack_cnt; // bytes the device failed to acknowledge
   // idle bus: clock parked high, data released to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      nack_cnt = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one bit, 8 clk: data moves only while scl is low, sampled late in the high phase
   task automatic one_bit(input logic b, output logic r);
      @(negedge clk_i) scl_o = 1'b0;
      @(negedge clk_i) sda_oe_o = !b;
      repeat (3) @(negedge clk_i);
      scl_o = 1'b1;
      repeat (3) @(negedge clk_i);
      r = sda_i;
   endtask : one_bit
   // start from idle: data falls while the clock is high
   task automatic start_c;
      @(negedge clk_i) sda_oe_o = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask : start_c
   // stop or repeated start; long low phase lets the device drop its ack first
   task automatic cond(input logic stop);
      @(negedge clk_i) scl_o = 1'b0;
      repeat (6) @(negedge clk_i);
      sda_oe_o = stop;
      repeat (2) @(negedge clk_i);
      scl_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sda_oe_o = !stop;
      repeat (4) @(negedge clk_i);
   endtask : cond
   // byte out, msb first, then the device's ack slot
   task automatic send_byte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) one_bit(d[i], r);
      one_bit(1'b1, r);
      if (r !== 1'b0) nack_cnt++;
   endtask : send_byte
   // byte in; the last one gets a nack so the device lets go
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) one_bit(1'b1, d[i]);
      one_bit(last, r);
   endtask : recv_byte
   ////////////////////////////////////////////////////////////////////////////////
   // write burst: address, pointer, then n bytes; whole access far below one second
   task automatic wr(input logic [7:0] ptr, input logic [95:0] d, input int n);
      start_c();
      send_byte({`RTC_DEV_ADDR, 1'b0});
      send_byte(ptr);
      for (int k = 0; k < n; k++) send_byte(d[95 - 8 * k -: 8]);
      cond(1'b1);
   endtask : wr
   // read burst: set pointer, repeated start, read address, n bytes
   task automatic rd(input logic [7:0] ptr, input int n, output logic [95:0] d);
      logic [7:0] b;
      d = '0;
      start_c();
      send_byte({`RTC_DEV_ADDR, 1'b0});
      send_byte(ptr);
      cond(1'b0);
      send_byte({`RTC_DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         recv_byte(k == n - 1, b);
         d[95 - 8 * k -: 8] = b;
      end
      cond(1'b1);
   endtask : rd
   // address-only probe; reports the ack and leaves the nack count alone
   task automatic probe(input logic [7:0] a, output logic ack);
      int n0;
      n0 = nack_cnt;
      start_c();
      send_byte(a);
      cond(1'b1);
      ack = (nack_cnt == n0);
      nack_cnt = n0;
   endtask : probe
   // tuning error in ppm of a measured count against its nominal count
   function automatic int freq_err_ppm(input int f, input int nom);
      return (f - nom) * 1000000 / nom;
   endfunction : freq_err_ppm
endmodule : rtc_i2c_master

/* File: rtc_time_access_and_tuning_test.sv */
// self-checking bench of the clock block: registers, calendar, clock output
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_time_access_and_tuning_test;
   logic clk = 1'b0; // 25 MHz system clock
   logic sys_rst = 1'b1; // held for 20 cycles at start
   logic scl; // host clock line
   logic m_oe; // host pulls data low
   logic d_sda; // device data value
   logic d_oe; // device pulls data low
   logic xtal = 1'b0; // fast crystal stand-in, 800 ns period
   logic xtal_run = 1'b1; // cleared to starve the stop watchdog
   logic clk_mon; // re-timed crystal output
   logic cap; // load capacitance select
   logic [95:0] got; // bytes read back
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   wire sda = !m_oe && !(d_oe && !d_sda); // open drain with pull-up
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 clk = ~clk;
   end
   // crystal toggles on falling system edges; stands still when stopped
   initial begin
      forever begin
         #400;
         if (xtal_run) xtal = ~xtal;
      end
   end
   rtc_core_top #(.XTAL_HZ(128), .CORR_M0_SEC(6), .CORR_M1_SEC(3)) i_rtc_core_top (
      .clk_i(clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
      .sda_oe_o(d_oe), .xtal_i(xtal), .clock_output_pin_o(clk_mon), .cap_12p5_o(cap));
   rtc_i2c_master i_rtc_i2c_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   // bytewise compare from the top of the packed buffers
   task automatic cmp_bytes(input logic [95:0] g, input logic [95:0] e, input int n);
      for (int k = 0; k < n; k++) check(g[95 - 8 * k -: 8], e[95 - 8 * k -: 8]);
   endtask : cmp_bytes
   // control and offset at zero, then the seven time bytes from the seconds slot
   task automatic set_clock(input logic [7:0] c, input logic [7:0] o, input logic [55:0] t);
      i_rtc_i2c_master.wr(`RTC_REG_CTRL, {c, 8'h00, o, 72'h0}, 3);
      i_rtc_i2c_master.wr(`RTC_REG_SEC, {t, 40'h0}, 7);
   endtask : set_clock
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   // reset image of every slot, read past the end so the pointer wraps
   task automatic t_reset;
      i_rtc_i2c_master.rd(`RTC_REG_CTRL, 12, got);
      cmp_bytes(got, 96'h0000_0000_8000_0001_0001_0000, 12);
      check({7'h0, cap}, 8'h00);
      $display("test reset done");
   endtask : t_reset
   // 12-hour pm time, 12.5 pF, mode 1 offset; holes at 01 and 03 read zero
   task automatic t_set_time;
      set_clock(8'h03, 8'h85, 56'h0045_2315_0412_11);
      check({7'h0, cap}, 8'h01);
      i_rtc_i2c_master.rd(`RTC_REG_CTRL, 11, got);
      cmp_bytes(got, 96'h0300_8500_0045_2315_0412_1100, 11);
      i_rtc_i2c_master.wr(`RTC_REG_CTRL, {8'h02, 88'h0}, 1);
      repeat (2) @(negedge clk);
      check({7'h0, cap}, 8'h00);
      check(i_rtc_i2c_master.nack_cnt[7:0], 8'h00);
      $display("test set_time done");
   endtask : t_set_time
   // one second after setting, all carries land; 3000 clk spans one 2560 clk second
   task automatic t_roll(input logic [7:0] c, input logic [55:0] t, input logic [55:0] e);
      set_clock(c, 8'h00, t);
      repeat (3000) @(negedge clk);
      i_rtc_i2c_master.rd(`RTC_REG_SEC, 7, got);
      cmp_bytes(got, {e, 40'h0}, 7);
      $display("test roll done");
   endtask : t_roll
   // rising edges of the clock output over 40 crystal periods
   task automatic t_clock_output_pin;
      int n;
      logic prev;
      @(posedge clk_mon);
      n = 0;
      prev = 1'b1;
      repeat (810) begin
         @(negedge clk);
         if (clk_mon && !prev) n++;
         prev = clk_mon;
      end
      check(n[7:0], 8'h28);
      check({7'h0, i_rtc_i2c_master.freq_err_ppm(n, 40) == 0}, 8'h01);
      $display("test clock_output_pin done");
   endtask : t_clock_output_pin
   // foreign address gets no ack
   task automatic t_bad_addr;
      logic ack;
      i_rtc_i2c_master.probe({`RTC_DEV_ADDR + 7'h01, 1'b0}, ack);
      check({7'h0, ack}, 8'h00);
      $display("test bad_addr done");
   endtask : t_bad_addr
   // offset +63 shortens one second per period; the read falls between the
   // corrected and the uncorrected end of that period
   task automatic t_corr(input logic [7:0] o, input int w, input logic [7:0] e);
      i_rtc_i2c_master.wr(`RTC_REG_OFFS, {o, 88'h0}, 1);
      i_rtc_i2c_master.wr(`RTC_REG_SEC, {8'h00, 88'h0}, 1);
      repeat (w) @(negedge clk);
      i_rtc_i2c_master.rd(`RTC_REG_SEC, 1, got);
      check(got[95:88], e);
      $display("test corr done");
   endtask : t_corr
   // crystal halted past the watchdog: stop flag must come back
   task automatic t_stop;
      xtal_run = 1'b0;
      repeat (3200) @(negedge clk);
      i_rtc_i2c_master.rd(`RTC_REG_SEC, 1, got);
      check({7'h0, got[95]}, 8'h01);
      xtal_run = 1'b1;
      $display("test stop done");
   endtask : t_stop
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, well above the roughly 50000 clk the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_set_time();
      t_roll(8'h02, 56'h5959_3131_0612_99, 56'h0000_1201_0001_00);
      t_roll(8'h02, 56'h5959_1130_0104_20, 56'h0000_3230_0104_20);
      t_roll(8'h00, 56'h5959_2328_0302_04, 56'h0000_0029_0402_04);
      t_roll(8'h00, 56'h5959_2328_0302_03, 56'h0000_0001_0403_03);
      t_clock_output_pin();
      t_bad_addr();
      t_corr(8'hBF, 6900, 8'h03);
      t_corr(8'h3F, 14700, 8'h06);
      t_stop();
      give_verdict();
   end
endmodule : rtc_time_access_and_tuning_test
